/* hw/scp_pkg.sv */
// constants for the sector and otp protection block
// assumes a 200 MHz device clock and word-addressed (16-bit) otp space
package scp_pkg;

  // ==========================================================
  // sizes
  localparam int SECTORS = 256;
  localparam int SECT_W = 8;
  localparam int OTP_AW = 9;
  localparam int OTP_WORDS = 512;
  localparam int TMR_W = 28;

  // ==========================================================
  // otp secure region map (word addresses)
  localparam logic [8:0] RAND_LAST = 9'h007;
  localparam logic [8:0] LOCK_WORD0 = 9'h008;
  localparam logic [8:0] OTP_LAST = 9'h1ff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int REGION_LSB = 4;

  // ==========================================================
  // config word fields
  localparam int FREEZE_BIT = 10;
  localparam int PWD_MODE_BIT = 1;
  localparam int PERS_MODE_BIT = 2;

  // ==========================================================
  // reset values
  localparam logic LOCK_RST = 1'b0;
  localparam logic [SECTORS-1:0] GUARD_RST = {SECTORS{1'b1}};

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int WORD_PROG_US = 500;
  localparam int SECT_ERASE_US = 930000;
  localparam int PROG_CYC = WORD_PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = SECT_ERASE_US * CLK_MHZ;

  // ==========================================================
  // command codes
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_OTP_ENTER = 4'h1,
    CMD_OTP_EXIT = 4'h2,
    CMD_OTP_PROG = 4'h3,
    CMD_NVG_ENTER = 4'h4,
    CMD_NVG_EXIT = 4'h5,
    CMD_NVG_PROG = 4'h6,
    CMD_NVG_ERASE = 4'h7,
    CMD_NVG_READ = 4'h8,
    CMD_VG_PROTECT = 4'h9,
    CMD_VG_UNPROTECT = 4'ha,
    CMD_LOCK_CLR = 4'hb,
    CMD_PWD_UNLOCK = 4'hc
  } scp_cmd_t;

endpackage

/* hw/scp_protect.sv */
// sector guard bits, guard lock flag and otp secure region programming
// assumes commands come from same-clock logic, one per ready cycle
//
// Function
// R1: otp programs like array; repeatable; never erased (each hardware reset reruns the init sweep, rewriting every word)
// R2: otp address drops A9 and above
// R3: freeze bit 0 fails otp program silently
// R4: protection mode does not guard otp
// R5: otp exit returns to read mode
// R6: otp map: random, lock bytes, regions
// R7: reserved and user words ship erased
// R8: either sector guard 0 blocks sector
// R9: guard lock 0 shields persistent guards
// R10: persistent mode: reset sets lock, soft keeps
// R11: persistent mode: only lock-clear, to 0
// R12: password mode: reset clears lock
// R13: password match sets lock to 1
// R14: password mode: lock-clear anytime clears
// R15: config word bits choose lock mode
// R16: host clears lock after guards configured
// R17: guards programmed singly, erased together
// R18: program/erase timed, status shows done
// R19: locked guard program/erase aborts, fails
// R20: guard overlay read returns sector guard
// R21: volatile guards reset unprotected, gated
// R22: volatile guard set/clear any time
`timescale 1ns/1ps

module scp_protect #(
  parameter int PROG_CYC = scp_pkg::PROG_CYC,
  parameter int ERASE_CYC = scp_pkg::ERASE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic sw_reset_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [3:0] cmd_code_i,
  input wire logic [scp_pkg::SECT_W-1:0] cmd_sector_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [63:0] cmd_data_i,
  input wire logic [15:0] protection_config_word_i,
  input wire logic [15:0] volatile_config_word_i,
  input wire logic [63:0] hidden_password_i,
  input wire logic [127:0] otp_random_i,
  input wire logic [scp_pkg::SECT_W-1:0] array_sector_i,
  output logic array_write_ok_o,
  output logic busy_o,
  output logic done_o,
  output logic prog_fail_o,
  output logic erase_fail_o,
  output logic rsp_valid_o,
  output logic rsp_guard_o,
  output logic ovl_otp_o,
  output logic ovl_nvg_o,
  output logic guard_lock_flag_o,
  output logic pwd_mode_o
);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================
  // state
  typedef enum logic [1:0] {OV_READ, OV_OTP, OV_NVG} scp_ovl_t;
  typedef enum logic [2:0] {
    E_INIT, E_IDLE, E_OTP, E_NVP, E_PRE, E_ERA
  } scp_eng_t;

  typedef struct packed {
    scp_ovl_t ovl;
    scp_eng_t eng;
    logic lock;
    logic [scp_pkg::SECTORS-1:0] nvg;
    logic [scp_pkg::SECTORS-1:0] vg;
    logic [scp_pkg::TMR_W-1:0] tmr;
    logic [scp_pkg::SECT_W-1:0] sect;
    logic [scp_pkg::OTP_AW-1:0] waddr;
    logic [15:0] wdata;
    logic abort;
    logic done;
    logic pfail;
    logic efail;
    logic rsp_v;
    logic rsp_g;
    logic wok;
  } scp_st_t;

  localparam logic [scp_pkg::TMR_W-1:0] PROG_LAST =
    scp_pkg::TMR_W'(PROG_CYC - 1);
  localparam logic [scp_pkg::TMR_W-1:0] ERASE_LAST =
    scp_pkg::TMR_W'(ERASE_CYC - 1);

  scp_st_t st_reg;
  scp_st_t st_next;
  logic [15:0] otp_mem [scp_pkg::OTP_WORDS];
  logic mem_we;
  logic [15:0] mem_wd;
  logic acc;
  logic pwd_mode;
  logic freeze_off;
  logic tmr_zero;
  logic [scp_pkg::OTP_AW-1:0] caddr;
  logic [15:0] lock_word;
  logic region_locked;
  logic rand_hit;

  assign acc = cmd_valid_i & cmd_ready_o;
  assign tmr_zero = (st_reg.tmr == '0);
  // R15: mode from config
  assign pwd_mode = ~protection_config_word_i[scp_pkg::PWD_MODE_BIT];
  assign freeze_off = ~volatile_config_word_i[scp_pkg::FREEZE_BIT];
  // R2: alias otp address
  assign caddr = cmd_addr_i[scp_pkg::OTP_AW-1:0];
  // R6: region lock lookup
  assign lock_word = otp_mem[scp_pkg::LOCK_WORD0 +
    {8'h00, caddr[scp_pkg::OTP_AW-1]}];
  assign region_locked = ~lock_word[caddr[scp_pkg::OTP_AW-2 -: 4]];
  assign rand_hit = (caddr <= scp_pkg::RAND_LAST);

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.rsp_v = 1'b0;
    // R8: either guard blocks
    // R21: volatile guard gated
    st_next.wok = st_reg.nvg[array_sector_i] & st_reg.vg[array_sector_i];
    mem_we = 1'b0;
    mem_wd = scp_pkg::ERASED_WORD;
    if (sw_reset_i) begin
      st_next.ovl = OV_READ;
    end
    unique case (st_reg.eng)
      E_INIT: begin
        // R7: region ships erased
        mem_we = 1'b1;
        if (st_reg.waddr <= scp_pkg::RAND_LAST) begin
          mem_wd = otp_random_i[st_reg.waddr[2:0]*16 +: 16];
        end
        st_next.waddr = st_reg.waddr + 1'b1;
        if (st_reg.waddr == scp_pkg::OTP_LAST) begin
          st_next.eng = E_IDLE;
          // R10: persistent sets lock
          // R12: password clears lock
          st_next.lock = ~pwd_mode;
        end
      end
      E_IDLE: begin
        if (acc) begin
          unique case (cmd_code_i)
            scp_pkg::CMD_OTP_ENTER: st_next.ovl = OV_OTP;
            // R5: exit to read
            scp_pkg::CMD_OTP_EXIT: st_next.ovl = OV_READ;
            scp_pkg::CMD_NVG_ENTER: st_next.ovl = OV_NVG;
            scp_pkg::CMD_NVG_EXIT: st_next.ovl = OV_READ;
            scp_pkg::CMD_OTP_PROG: begin
              if (st_reg.ovl == OV_OTP) begin
                st_next.waddr = caddr;
                st_next.wdata = cmd_data_i[15:0];
                st_next.pfail = 1'b0;
                // R3: freeze fails silently
                // R4: mode not consulted
                if (freeze_off) begin
                  st_next.done = 1'b1;
                end else if (region_locked ||
                    (rand_hit && cmd_data_i[15:0] != 16'hffff)) begin
                  st_next.pfail = 1'b1;
                  st_next.done = 1'b1;
                end else begin
                  st_next.eng = E_OTP;
                  st_next.tmr = PROG_LAST;
                end
              end
            end
            scp_pkg::CMD_NVG_PROG: begin
              if (st_reg.ovl == OV_NVG) begin
                // R9: lock shields guards
                st_next.abort = ~st_reg.lock;
                st_next.sect = cmd_sector_i;
                st_next.pfail = 1'b0;
                st_next.eng = E_NVP;
                st_next.tmr = PROG_LAST;
              end
            end
            scp_pkg::CMD_NVG_ERASE: begin
              if (st_reg.ovl == OV_NVG) begin
                st_next.abort = ~st_reg.lock;
                st_next.efail = 1'b0;
                st_next.eng = E_PRE;
                st_next.tmr = PROG_LAST;
              end
            end
            scp_pkg::CMD_NVG_READ: begin
              // R20: guard status read
              if (st_reg.ovl == OV_NVG) begin
                st_next.rsp_v = 1'b1;
                st_next.rsp_g = st_reg.nvg[cmd_sector_i];
              end
            end
            // R22: volatile set/clear
            scp_pkg::CMD_VG_PROTECT: st_next.vg[cmd_sector_i] = 1'b0;
            scp_pkg::CMD_VG_UNPROTECT: st_next.vg[cmd_sector_i] = 1'b1;
            // R11: only clear in persistent
            // R14: clear in password mode
            scp_pkg::CMD_LOCK_CLR: st_next.lock = 1'b0;
            scp_pkg::CMD_PWD_UNLOCK: begin
              // R13: match sets lock
              if (pwd_mode && cmd_data_i == hidden_password_i) begin
                st_next.lock = 1'b1;
              end
            end
            default: st_next.eng = E_IDLE;
          endcase
        end
      end
      E_OTP: begin
        st_next.tmr = st_reg.tmr - 1'b1;
        if (tmr_zero) begin
          // R1: program only clears bits
          mem_we = 1'b1;
          mem_wd = otp_mem[st_reg.waddr] & st_reg.wdata;
          st_next.eng = E_IDLE;
          st_next.done = 1'b1;
        end
      end
      E_NVP: begin
        st_next.tmr = st_reg.tmr - 1'b1;
        if (tmr_zero) begin
          // R18: timed then done
          // R19: abort flags failure
          if (st_reg.abort) begin
            st_next.pfail = 1'b1;
          end else begin
            // R17: single guard program
            st_next.nvg[st_reg.sect] = 1'b0;
          end
          st_next.eng = E_IDLE;
          st_next.done = 1'b1;
        end
      end
      E_PRE: begin
        // R17: preprogram before erase
        st_next.tmr = st_reg.tmr - 1'b1;
        if (tmr_zero) begin
          st_next.eng = E_ERA;
          st_next.tmr = ERASE_LAST;
        end
      end
      E_ERA: begin
        st_next.tmr = st_reg.tmr - 1'b1;
        if (tmr_zero) begin
          // R19: abort flags failure
          if (st_reg.abort) begin
            st_next.efail = 1'b1;
          end else begin
            // R17: erase all guards
            st_next.nvg = scp_pkg::GUARD_RST;
          end
          st_next.eng = E_IDLE;
          st_next.done = 1'b1;
        end
      end
      default: st_next.eng = E_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{ovl: OV_READ, eng: E_INIT, lock: scp_pkg::LOCK_RST,
                  nvg: scp_pkg::GUARD_RST, vg: scp_pkg::GUARD_RST,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // otp storage is not reset; the init sweep fills it
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      otp_mem[st_reg.waddr] <= mem_wd;
    end
  end

  // ==========================================================
  // outputs
  assign cmd_ready_o = (st_reg.eng == E_IDLE);
  assign array_write_ok_o = st_reg.wok;
  assign busy_o = (st_reg.eng != E_IDLE);
  assign done_o = st_reg.done;
  assign prog_fail_o = st_reg.pfail;
  assign erase_fail_o = st_reg.efail;
  assign rsp_valid_o = st_reg.rsp_v;
  assign rsp_guard_o = st_reg.rsp_g;
  assign ovl_otp_o = (st_reg.ovl == OV_OTP);
  assign ovl_nvg_o = (st_reg.ovl == OV_NVG);
  assign guard_lock_flag_o = st_reg.lock;
  assign pwd_mode_o = pwd_mode;

  // ==========================================================
  // checks
  sequence otp_prog_s;
    acc && cmd_code_i == scp_pkg::CMD_OTP_PROG && ovl_otp_o;
  endsequence

  sequence nvg_read_s;
    acc && cmd_code_i == scp_pkg::CMD_NVG_READ && ovl_nvg_o;
  endsequence

  // R3: freeze silent fail
  otp_freeze_a: assert property (otp_prog_s and freeze_off // R3
    |=> done_o && !prog_fail_o && cmd_ready_o)
    else $error("frozen otp program not silently dropped");

  // R5: exit overlay
  otp_exit_a: assert property (acc && !sw_reset_i && // R5
    cmd_code_i == scp_pkg::CMD_OTP_EXIT |=> !ovl_otp_o && !ovl_nvg_o)
    else $error("otp exit did not return to read mode");

  // R11: clear lock
  lock_clear_a: assert property (acc && // R11
    cmd_code_i == scp_pkg::CMD_LOCK_CLR |=> !guard_lock_flag_o ##1
    (pwd_mode_o || !guard_lock_flag_o))
    else $error("lock clear did not hold lock at 0");

  // R13: bad password
  pwd_reject_a: assert property (acc && !guard_lock_flag_o && // R13
    cmd_data_i != hidden_password_i |=> !guard_lock_flag_o)
    else $error("lock set without matching password");

  // R10: soft reset keeps lock
  soft_reset_a: assert property (sw_reset_i && !acc && // R10
    st_reg.eng != E_INIT
    |=> $stable(guard_lock_flag_o) && !ovl_otp_o)
    else $error("software reset disturbed lock flag");

  // R19: locked guard program
  guard_abort_a: assert property (st_reg.eng == E_NVP && tmr_zero && // R19
    st_reg.abort |=> prog_fail_o && done_o && $stable(st_reg.nvg))
    else $error("locked guard program not aborted");

  // R20: guard status read
  guard_read_a: assert property (nvg_read_s |=> rsp_valid_o && // R20
    rsp_guard_o == st_reg.nvg[$past(cmd_sector_i)])
    else $error("guard read returned wrong state");

  // R17: collective erase
  erase_all_a: assert property (st_reg.eng == E_ERA && tmr_zero && // R17
    !st_reg.abort |=> erase_fail_o == 1'b0 && &st_reg.nvg)
    else $error("guard erase left guards protected");

  // R22: volatile protect
  vg_protect_a: assert property (acc && // R22
    cmd_code_i == scp_pkg::CMD_VG_PROTECT
    |=> ##1 !array_write_ok_o ||
    $past(array_sector_i) != $past(cmd_sector_i, 2))
    else $error("volatile protect left sector writable");

endmodule

/* dv/scp_host_model.sv */
// host controller model: sends one command at a time to the block
// assumes the block takes a request on a rising edge while ready is high
`timescale 1ns/1ps

module scp_host_model (
  input wire logic ref_clk_i,
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [7:0] cmd_sector_o,
  output logic [15:0] cmd_addr_o,
  output logic [63:0] cmd_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_sector_o = 8'h00;
    cmd_addr_o = 16'h0000;
    cmd_data_o = 64'h0;
  end

  // =========================================================
  // request hold
  task automatic send(input logic [3:0] c, input logic [7:0] s,
                      input logic [15:0] a, input logic [63:0] d,
                      output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = c;
    cmd_sector_o = s;
    cmd_addr_o = a;
    cmd_data_o = d;
    while (!ok && n < 200) begin
      if (cmd_ready_i === 1'b1) begin
        @(posedge ref_clk_i);
        ok = 1'b1;
      end else begin
        @(negedge ref_clk_i);
        n++;
      end
    end
    @(negedge ref_clk_i);
    // released fields show junk, not the last request
    cmd_valid_o = 1'b0;
    cmd_code_o = ~c;
    cmd_sector_o = ~s;
    cmd_addr_o = ~a;
    cmd_data_o = ~d;
  endtask
endmodule

/* dv/tb_scp_protect.sv */
// bench for the sector and otp protection block
// assumes short program and erase counts set at the instance
`timescale 1ns/1ps

module tb_scp_protect;
  localparam int PROG = 8;
  localparam int ERASE = 16;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sw_reset_i = 1'b0;
  logic [15:0] pcfg = 16'hfffb;
  logic [15:0] vcfg = 16'hffff;
  logic [63:0] pwd = 64'h0;
  logic [127:0] rnd = 128'h0;
  logic [7:0] asec = 8'h00;
  logic cmd_valid, cmd_ready, wr_ok, busy, done, pfail, efail;
  logic rsp_v, rsp_g, o_otp, o_nvg, lock, pmode;
  logic [3:0] code;
  logic [7:0] sec;
  logic [15:0] addr;
  logic [63:0] data;
  logic [7:0] s;
  logic [15:0] r;
  int mismatches = 0;
  int samples_checked = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  scp_host_model host_u (.ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready),
    .cmd_valid_o(cmd_valid), .cmd_code_o(code), .cmd_sector_o(sec),
    .cmd_addr_o(addr), .cmd_data_o(data));

  scp_protect #(.PROG_CYC(PROG), .ERASE_CYC(ERASE)) dut_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sw_reset_i(sw_reset_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_code_i(code),
    .cmd_sector_i(sec), .cmd_addr_i(addr), .cmd_data_i(data),
    .protection_config_word_i(pcfg), .volatile_config_word_i(vcfg),
    .hidden_password_i(pwd), .otp_random_i(rnd), .array_sector_i(asec),
    .array_write_ok_o(wr_ok), .busy_o(busy), .done_o(done),
    .prog_fail_o(pfail), .erase_fail_o(efail), .rsp_valid_o(rsp_v),
    .rsp_guard_o(rsp_g), .ovl_otp_o(o_otp), .ovl_nvg_o(o_nvg),
    .guard_lock_flag_o(lock), .pwd_mode_o(pmode));

  // =========================================================
  // checking and control tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic fail_now(input string what);
    mismatches++;
    $display("Error at %0t: %s timed out", $time, what);
    test_done();
  endtask

  task automatic cmd(input logic [3:0] c, input logic [7:0] sc,
                     input logic [15:0] a, input logic [63:0] d);
    bit ok;
    host_u.send(c, sc, a, d, ok);
    if (!ok) fail_now("command");
  endtask

  task automatic op(input logic [3:0] c, input logic [7:0] sc,
                    input logic [15:0] a, input logic [63:0] d, input int mn);
    int n;
    cmd(c, sc, a, d);
    for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge ref_clk_i);
    if (done !== 1'b1) fail_now("done");
    chk(logic'(n >= mn), 1'b1, "op length");
    @(negedge ref_clk_i);
  endtask

  task automatic rd(input logic [7:0] sc, input logic exp);
    cmd(scp_pkg::CMD_NVG_READ, sc, 16'h0, 64'h0);
    chk(rsp_v, 1'b1, "read valid");
    chk(rsp_g, exp, "read guard");
  endtask

  task automatic wok(input logic [7:0] sc, input logic exp);
    asec = sc;
    repeat (2) @(negedge ref_clk_i);
    chk(wr_ok, exp, "write ok");
  endtask

  task automatic hw_reset(input logic [15:0] cfg);
    int n;
    rstn_i = 1'b0;
    pcfg = cfg;
    repeat (3) @(negedge ref_clk_i);
    chk(busy, 1'b1, "busy in reset");
    rstn_i = 1'b1;
    for (n = 0; n < 700 && cmd_ready !== 1'b1; n++) @(negedge ref_clk_i);
    if (cmd_ready !== 1'b1) fail_now("ready");
  endtask

  // =========================================================
  // main sequence
  initial begin
    void'($urandom(46703));
    rnd = {$urandom, $urandom, $urandom, $urandom};
    pwd = {$urandom, $urandom};
    hw_reset(16'hfffb);
    chk(pmode, 1'b0, "mode");
    chk(lock, 1'b1, "lock");
    repeat (4) begin
      s = 8'($urandom);
      wok(s, 1'b1);
      cmd(scp_pkg::CMD_VG_PROTECT, s, 16'h0, 64'h0);
      wok(s, 1'b0);
      wok(s ^ 8'h01, 1'b1);
      cmd(scp_pkg::CMD_VG_UNPROTECT, s, 16'h0, 64'h0);
      wok(s, 1'b1);
    end
    cmd(scp_pkg::CMD_NVG_ENTER, 8'h0, 16'h0, 64'h0);
    chk(o_nvg, 1'b1, "guard overlay");
    op(scp_pkg::CMD_NVG_PROG, s, 16'h0, 64'h0, PROG - 2);
    op(scp_pkg::CMD_NVG_PROG, s + 8'h2, 16'h0, 64'h0, PROG - 2);
    chk(pfail, 1'b0, "prog fail");
    rd(s, 1'b0);
    rd(s + 8'h1, 1'b1);
    wok(s, 1'b0);
    cmd(scp_pkg::CMD_VG_UNPROTECT, s, 16'h0, 64'h0);
    wok(s, 1'b0);
    op(scp_pkg::CMD_NVG_ERASE, 8'h0, 16'h0, 64'h0, ERASE);
    chk(efail, 1'b0, "erase fail");
    rd(s, 1'b1);
    rd(s + 8'h2, 1'b1);
    cmd(scp_pkg::CMD_LOCK_CLR, 8'h0, 16'h0, 64'h0);
    chk(lock, 1'b0, "lock clear");
    op(scp_pkg::CMD_NVG_PROG, s, 16'h0, 64'h0, PROG - 2);
    chk(pfail, 1'b1, "locked prog");
    rd(s, 1'b1);
    op(scp_pkg::CMD_NVG_ERASE, 8'h0, 16'h0, 64'h0, ERASE);
    chk(efail, 1'b1, "locked erase");
    sw_reset_i = 1'b1;
    @(negedge ref_clk_i);
    sw_reset_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(lock, 1'b0, "soft reset lock");
    chk(o_nvg, 1'b0, "soft reset overlay");
    cmd(scp_pkg::CMD_OTP_ENTER, 8'h0, 16'h0, 64'h0);
    chk(o_otp, 1'b1, "otp overlay");
    vcfg = 16'hfbff;
    op(scp_pkg::CMD_OTP_PROG, 8'h0, 16'h0020, 64'h0, 0);
    chk(pfail, 1'b0, "frozen");
    vcfg = 16'hffff;
    op(scp_pkg::CMD_OTP_PROG, 8'h0, 16'h0003, 64'h0, 0);
    chk(pfail, 1'b1, "random words");
    op(scp_pkg::CMD_OTP_PROG, 8'h0, 16'h000a, 64'h0, 0);
    chk(pfail, 1'b0, "reserved");
    r = 16'(1 + $urandom % 31);
    repeat (2) begin
      op(scp_pkg::CMD_OTP_PROG, 8'h0, r << 4, 64'($urandom), 0);
      chk(pfail, 1'b0, "repeat prog");
    end
    op(scp_pkg::CMD_OTP_PROG, 8'h0, 16'hfe08 + (r >> 4),
       64'(~(16'h1 << r[3:0])), 0);
    op(scp_pkg::CMD_OTP_PROG, 8'h0, (r << 4) + 16'h5, 64'h1, 0);
    chk(pfail, 1'b1, "locked region");
    op(scp_pkg::CMD_OTP_PROG, 8'h0, ((r ^ 16'h1) | 16'h2) << 4,
       64'h1, 0);
    chk(pfail, 1'b0, "open region");
    cmd(scp_pkg::CMD_OTP_EXIT, 8'h0, 16'h0, 64'h0);
    chk(o_otp, 1'b0, "otp exit");
    cmd(scp_pkg::CMD_OTP_PROG, 8'h0, 16'h0040, 64'h1);
    repeat (20) begin
      @(negedge ref_clk_i);
      chk(done, 1'b0, "ignored prog");
    end
    hw_reset(16'hfffd);
    chk(pmode, 1'b1, "mode");
    chk(lock, 1'b0, "lock");
    cmd(scp_pkg::CMD_PWD_UNLOCK, 8'h0, 16'h0,
        pwd ^ (64'h1 << ($urandom % 64)));
    chk(lock, 1'b0, "bad password");
    cmd(scp_pkg::CMD_PWD_UNLOCK, 8'h0, 16'h0, pwd);
    chk(lock, 1'b1, "password");
    cmd(scp_pkg::CMD_LOCK_CLR, 8'h0, 16'h0, 64'h0);
    chk(lock, 1'b0, "clear");
    cmd(scp_pkg::CMD_PWD_UNLOCK, 8'h0, 16'h0, pwd);
    chk(lock, 1'b1, "password again");
    hw_reset(16'hfffd);
    chk(lock, 1'b0, "lock");
    test_done();
  end
endmodule
